// File: rtl/idm_consts.svh
// constants for the internal data memory decoder
`ifndef IDM_CONSTS_SVH
`define IDM_CONSTS_SVH
`define IDM_RAM_BYTES 256
`define IDM_UPPER_BASE 8'h80
`define IDM_BANK_TOP 8'h1F
`define IDM_BITAREA_BASE 8'h20
`define IDM_BITAREA_TOP 8'h2F
`define IDM_FLASH_BYTES 16384
`define IDM_SECTOR_BYTES 512
`define IDM_ERASED_BYTE 8'hFF
`endif

// File: rtl/idm_pkg.sv
// types for the internal data memory decoder
package idm_pkg;
  typedef enum logic [1:0] {IDM_RAM_LO, IDM_RAM_HI, IDM_SFR} idm_target_t;
  typedef enum logic [1:0] {IDM_IDLE, IDM_ERASE} idm_fstate_t;
endpackage

// File: rtl/idm_ram.sv
// byte-wide flip-flop memory, one write and one read port
`timescale 1ns/100ps
module idm_ram #(
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  input wire logic CLK_SYS_I,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem_q [DEPTH];

  initial
  begin
    if (DEPTH > (1 << AW)) $error("idm_ram: depth exceeds address width");
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (we_i)
      mem_q[waddr_i] <= wdata_i;
  end

  assign rdata_o = mem_q[raddr_i];
endmodule

// File: rtl/idm_decoder.sv
// data memory decoder with register banks, bit area and flash store
// Function
// - 256 byte RAM, upper half shares SFR addresses
// - indirect upper access goes to upper RAM
// - direct upper access goes to SFR space
// - lower half same RAM for both modes
// - first 32 bytes are four register banks
// - next 16 bytes byte or bit addressable
// - 16 kB flash program memory, separate space
// - flash erased in 512 byte sectors in-system
`timescale 1ns/100ps
`include "idm_consts.svh"
module idm_decoder
  import idm_pkg::*;
#(
  parameter int FLASH_BYTES = `IDM_FLASH_BYTES,
  parameter int SECTOR_BYTES = `IDM_SECTOR_BYTES
) (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  // data access from the core
  input wire logic D_REQ_I,
  input wire logic D_WE_I,
  input wire logic D_INDIRECT_I,
  input wire logic D_BIT_I,
  input wire logic D_REG_I,
  input wire logic [7:0] D_ADDR_I,
  input wire logic [7:0] D_WDATA_I,
  input wire logic [1:0] BANK_SEL_I,
  output logic [7:0] D_RDATA_O,
  output logic D_BITOUT_O,
  output logic D_VALID_O,
  // special function register space
  output logic SFR_REQ_O,
  output logic SFR_WE_O,
  output logic [6:0] SFR_ADDR_O,
  output logic [7:0] SFR_WDATA_O,
  input wire logic [7:0] SFR_RDATA_I,
  // program memory
  input wire logic P_REQ_I,
  input wire logic [13:0] P_ADDR_I,
  output logic [7:0] P_RDATA_O,
  input wire logic F_WE_I,
  input wire logic F_ERASE_I,
  input wire logic [13:0] F_ADDR_I,
  input wire logic [7:0] F_WDATA_I,
  output logic F_BUSY_O
);
  localparam int FAW = $clog2(FLASH_BYTES);
  localparam int SAW = $clog2(SECTOR_BYTES);

  initial
  begin
    if (FLASH_BYTES != (1 << FAW) || FAW > 14)
      $error("idm_decoder: flash size must be a power of two up to 16 kB");
    if (SECTOR_BYTES != (1 << SAW) || SAW >= FAW)
      $error("idm_decoder: bad sector size");
  end

  // ****************************************
  // data space decode
  // ****************************************
  wire upper = D_ADDR_I >= `IDM_UPPER_BASE;
  wire to_sfr = upper && !D_INDIRECT_I && !D_REG_I;
  // working register: address 0..7 offset into the selected bank
  wire [7:0] reg_addr = {3'h0, BANK_SEL_I, D_ADDR_I[2:0]};
  // bit address 0..7F maps to bytes 20..2F
  wire [7:0] bit_byte = `IDM_BITAREA_BASE + {4'h0, D_ADDR_I[6:3]};
  wire [2:0] bit_pos = D_ADDR_I[2:0];
  wire bit_sfr = D_BIT_I && D_ADDR_I[7];
  wire [7:0] ram_addr = D_REG_I ? reg_addr :
                        D_BIT_I ? bit_byte : D_ADDR_I;
  wire ram_hit = D_REQ_I && !to_sfr && !bit_sfr;
  wire [7:0] ram_rd;
  wire [7:0] ram_wr = D_BIT_I ?
    ((ram_rd & ~(8'h01 << bit_pos)) | ({7'h00, D_WDATA_I[0]} << bit_pos)) :
    D_WDATA_I;

  idm_ram #(.DEPTH(`IDM_RAM_BYTES), .AW(8)) u_ram (
    .CLK_SYS_I(CLK_SYS_I),
    .we_i(ram_hit && D_WE_I),
    .waddr_i(ram_addr),
    .wdata_i(ram_wr),
    .raddr_i(ram_addr),
    .rdata_o(ram_rd)
  );

  // sfr bit address selects byte on an 8-aligned sfr, bit in low bits
  assign SFR_REQ_O = D_REQ_I && (to_sfr || bit_sfr);
  assign SFR_WE_O = D_WE_I;
  assign SFR_ADDR_O = bit_sfr ? {D_ADDR_I[6:3], 3'h0} : D_ADDR_I[6:0];
  assign SFR_WDATA_O = D_WDATA_I;

  wire [7:0] rd_sel = (to_sfr || bit_sfr) ? SFR_RDATA_I : ram_rd;

  always_ff @(posedge CLK_SYS_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      D_RDATA_O <= 8'h00;
      D_BITOUT_O <= 1'b0;
      D_VALID_O <= 1'b0;
    end
    else
    begin
      D_VALID_O <= D_REQ_I && !D_WE_I;
      if (D_REQ_I && !D_WE_I)
      begin
        D_RDATA_O <= rd_sel;
        D_BITOUT_O <= rd_sel[bit_pos];
      end
    end
  end

  // ****************************************
  // program flash
  // ****************************************
  logic [7:0] flash_q [FLASH_BYTES];
  logic [SAW-1:0] ecnt_q;
  logic [FAW-SAW-1:0] esec_q;
  idm_fstate_t fstate_q;

  wire erasing = fstate_q == IDM_ERASE;
  wire erase_last = ecnt_q == SAW'(SECTOR_BYTES - 1);

  always_ff @(posedge CLK_SYS_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      fstate_q <= IDM_IDLE;
      ecnt_q <= '0;
      esec_q <= '0;
    end
    else
    begin
      unique case (fstate_q)
        IDM_IDLE:
          if (F_ERASE_I)
          begin
            fstate_q <= IDM_ERASE;
            esec_q <= F_ADDR_I[FAW-1:SAW];
            ecnt_q <= '0;
          end
        IDM_ERASE:
        begin
          ecnt_q <= ecnt_q + 1'b1;
          if (erase_last)
            fstate_q <= IDM_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (erasing)
      flash_q[{esec_q, ecnt_q}] <= `IDM_ERASED_BYTE;
    else if (F_WE_I)
      flash_q[F_ADDR_I[FAW-1:0]] <= flash_q[F_ADDR_I[FAW-1:0]] & F_WDATA_I;
  end

  assign F_BUSY_O = erasing;

  always_ff @(posedge CLK_SYS_I or posedge RST_I)
  begin
    if (RST_I)
      P_RDATA_O <= 8'h00;
    else if (P_REQ_I)
      P_RDATA_O <= flash_q[P_ADDR_I[FAW-1:0]];
  end
endmodule

// File: bench/idm_sfr_model.sv
// stand-in for the special function register space
`timescale 1ns/100ps
module idm_sfr_model (
  input wire logic SFR_REQ_O,
  input wire logic [6:0] SFR_ADDR_O,
  output logic [7:0] SFR_RDATA_I
);
  // unselected it shows inverted data so stale values never match
  assign SFR_RDATA_I = {SFR_REQ_O, SFR_ADDR_O} ^ {8{!SFR_REQ_O}};
endmodule

// File: bench/idm_decoder_assertions.sv
// assertions on the data memory decoder ports
`timescale 1ns/100ps
module idm_chk (
  input wire logic CLK_SYS_I, RST_I, D_REQ_I, D_WE_I, D_BIT_I, D_REG_I,
  input wire logic D_INDIRECT_I, D_VALID_O, SFR_REQ_O, F_ERASE_I, F_BUSY_O,
  input wire logic [7:0] D_ADDR_I,
  input wire logic [6:0] SFR_ADDR_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  wire logic hi = D_REQ_I && D_ADDR_I[7] && !D_REG_I;
  wire logic byt = D_REQ_I && !D_BIT_I && !D_REG_I;
  sequence s_rd; D_REQ_I && !D_WE_I; endsequence
  sequence s_er; F_ERASE_I && !F_BUSY_O; endsequence
  AST_DIR: assert property (hi && !D_BIT_I && !D_INDIRECT_I |->
    SFR_REQ_O && SFR_ADDR_O == D_ADDR_I[6:0]) else $error("sfr");
  AST_IND: assert property (byt && D_INDIRECT_I |-> !SFR_REQ_O)
    else $error("ind");
  AST_LOW: assert property (byt && !D_ADDR_I[7] |-> !SFR_REQ_O)
    else $error("low");
  AST_REG: assert property (D_REQ_I && D_REG_I |-> !SFR_REQ_O)
    else $error("reg");
  AST_BIT: assert property (hi && D_BIT_I |-> SFR_REQ_O &&
    SFR_ADDR_O == {D_ADDR_I[6:3], 3'h0}) else $error("bit");
  AST_RD: assert property (s_rd |=> D_VALID_O) else $error("rd");
  AST_NRD: assert property (!(D_REQ_I && !D_WE_I) |=> !D_VALID_O)
    else $error("nrd");
  AST_ER: assert property (s_er |=> F_BUSY_O [*8]) else $error("er");
endmodule
bind idm_decoder idm_chk u_chk (.*);

// File: bench/tb_internal_data_memory_decoder.sv
// self-checking bench for the data memory decoder
`timescale 1ns/100ps
module tb_internal_data_memory_decoder;
  logic CLK_SYS_I = '0, RST_I = '1, D_REQ_I = '0, D_WE_I = '0, D_BIT_I = '0;
  logic D_INDIRECT_I = '0, D_REG_I = '0, P_REQ_I = '0, F_WE_I = '0;
  logic F_ERASE_I = '0, D_BITOUT_O, D_VALID_O, SFR_REQ_O, SFR_WE_O, F_BUSY_O;
  logic [1:0] BANK_SEL_I = '0;
  logic [6:0] SFR_ADDR_O;
  logic [7:0] D_ADDR_I = '0, D_WDATA_I = '0, F_WDATA_I = '0, D_RDATA_O;
  logic [7:0] SFR_RDATA_I, SFR_WDATA_O, P_RDATA_O;
  logic [13:0] P_ADDR_I = '0, F_ADDR_I = '0;
  int failures = 0, num_checks = 0;
  always #50 CLK_SYS_I = ~CLK_SYS_I;
  idm_decoder #(.SECTOR_BYTES(16)) uut (.*);
  idm_sfr_model sfr (.*);
  task automatic chk(input logic [7:0] g, e);
    num_checks++;
    if (g !== e)
    begin
      failures++;
      $display("wrong value at %0t: %h", $time, g);
    end
  endtask
  task automatic acc(input logic [3:0] k, input logic [7:0] a, d, e);
    {D_WE_I, D_INDIRECT_I, D_BIT_I, D_REG_I} = k;
    {D_ADDR_I, D_WDATA_I, D_REQ_I} = {a, d, 1'b1};
    @(posedge CLK_SYS_I);
    if (SFR_REQ_O)
      chk({SFR_WE_O, SFR_WDATA_O[6:0]}, {k[3], d[6:0]});
    #1;
    chk({7'h00, D_VALID_O}, {7'h00, !k[3]});
    if (!k[3])
      chk(k[1] ? {7'h00, D_BITOUT_O} : D_RDATA_O, e);
  endtask
  task automatic t_dual;
    acc(4'hC, 8'h81, 8'h44, 8'h00);
    acc(4'h8, 8'h81, 8'h99, 8'h00);
    acc(4'h0, 8'h85, 8'h00, 8'h85);
    acc(4'h4, 8'h81, 8'h00, 8'h44);
  endtask
  task automatic t_bank;
    BANK_SEL_I = 2'h2;
    acc(4'h9, 8'h03, 8'h33, 8'h00);
    acc(4'h4, 8'h13, 8'h00, 8'h33);
  endtask
  task automatic t_bit;
    acc(4'h8, 8'h21, 8'h00, 8'h00);
    acc(4'hA, 8'h0A, 8'h01, 8'h00);
    acc(4'h4, 8'h21, 8'h00, 8'h04);
    acc(4'h2, 8'h8B, 8'h00, 8'h01);
  endtask
  task automatic t_flash;
    {D_REQ_I, F_ERASE_I, F_ADDR_I} = {2'h1, 14'h0013};
    @(posedge CLK_SYS_I) #1;
    F_ERASE_I = '0;
    chk({7'h00, F_BUSY_O}, 8'h01);
    repeat (18) @(posedge CLK_SYS_I) #1;
    chk({7'h00, F_BUSY_O}, 8'h00);
    {F_WE_I, F_WDATA_I, P_REQ_I, P_ADDR_I} = {9'h15A, 1'b1, 14'h001F};
    @(posedge CLK_SYS_I) #1;
    chk(P_RDATA_O, 8'hFF);
    {F_WE_I, P_ADDR_I} = {1'b0, 14'h0013};
    @(posedge CLK_SYS_I) #1;
    chk(P_RDATA_O, 8'h5A);
  endtask
  task automatic end_of_test;
    if (failures == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge CLK_SYS_I);
    #1 RST_I = '0;
    t_dual;
    t_bank;
    t_bit;
    t_flash;
    end_of_test;
  end
endmodule
